// file: bcs_pkg.sv
// Purpose: Shared constants and types for the branch, call and skip unit.
// Assumes: 22-bit word program counter, 8-bit working registers.
// Notes:   Cycle figures are whole core clocks at 40 MHz.
package bcs_pkg;
  // Widths.
  localparam int PC_W  = 22;
  localparam int OFF_W = 7;
  localparam int CNT_W = 3;

  // Status flag bit positions.
  localparam int FLG_C = 0;
  localparam int FLG_Z = 1;
  localparam int FLG_N = 2;
  localparam int FLG_V = 3;
  localparam int FLG_S = 4;
  localparam int FLG_H = 5;
  localparam int FLG_T = 6;
  localparam int FLG_I = 7;

  // Reset values.
  localparam logic [PC_W-1:0] PC_RST   = 22'h000000;
  localparam logic [7:0]      STATUS_FLAGS_REGISTER_RST = 8'h00;

  // Program counter reach: one selects the three-byte return address timing.
  localparam bit PC_WIDE = 1'b1;

  // Cycle counts.
  localparam logic [CNT_W-1:0] CYC_ONE           = 3'h1;
  localparam logic [CNT_W-1:0] CYC_TAKEN         = 3'h2;
  localparam logic [CNT_W-1:0] CYC_PTR_CALL_NARR = 3'h2;
  localparam logic [CNT_W-1:0] CYC_PTR_CALL_WIDE = 3'h3;
  localparam logic [CNT_W-1:0] CYC_EXT_CALL      = 3'h3;
  localparam logic [CNT_W-1:0] CYC_RET_NARR      = 3'h4;
  localparam logic [CNT_W-1:0] CYC_RET_WIDE      = 3'h5;
  localparam logic [CNT_W-1:0] CYC_IO_EXTRA      = 3'h1;

  // Program counter steps.
  localparam logic [PC_W-1:0] STEP_NEXT     = 22'h000001;
  localparam logic [PC_W-1:0] STEP_SKIP_ONE = 22'h000002;
  localparam logic [PC_W-1:0] STEP_SKIP_TWO = 22'h000003;

  // Instructions handled by the unit.
  typedef enum logic [5:0] {
    OP_PTR_CALL, OP_EXT_PTR_CALL, OP_SUB_EXIT, OP_IRQ_EXIT,
    OP_CMP_SKIP, OP_CMP_REGS, OP_CMP_CARRY, OP_CMP_IMM,
    OP_SKIP_RBIT0, OP_SKIP_RBIT1, OP_SKIP_IO0, OP_SKIP_IO1,
    OP_BR_SBIT1, OP_BR_SBIT0, OP_BR_ZERO1, OP_BR_ZERO0,
    OP_BR_CARRY1, OP_BR_CARRY0, OP_BR_UGE, OP_BR_ULT,
    OP_BR_NEG, OP_BR_NONNEG, OP_BR_SGE, OP_BR_SLT,
    OP_BR_HALF1, OP_BR_HALF0, OP_BR_USER1, OP_BR_USER0,
    OP_BR_OVF1, OP_BR_OVF0, OP_BR_IRQ1, OP_BR_IRQ0,
    OP_COPY, OP_COPY_PAIR
  } bcs_op_e;

  typedef enum logic [0:0] {PH_IDLE, PH_RUN} bcs_phase_e;
endpackage

// file: bcs_cmp_if.sv
// Purpose: Carries compare operands and resulting flags between modules.
// Assumes: Purely combinational path.
// Notes:   The user side drives operands, the calc side returns flags.
`timescale 1ns/100ps
interface bcs_cmp_if;
  logic [7:0] opA;
  logic [7:0] opB;
  logic       withCarry;
  logic [7:0] oldFlags;
  logic [7:0] newFlags;

  modport user (output opA, output opB, output withCarry, output oldFlags, input newFlags);
  modport calc (input opA, input opB, input withCarry, input oldFlags, output newFlags);
endinterface

// file: bcs_cmp_flags.sv
// Purpose: Flag generation for the subtract-and-discard compare forms.
// Assumes: Operands are stable for the cycle in which flags are used.
// Notes:   No result is produced, only the new status byte.
`timescale 1ns/100ps
module bcs_cmp_flags (
  // Compare operands and flags.
  bcs_cmp_if.calc cmp
);
  import bcs_pkg::*;

  logic [7:0] diff;
  logic       cin;

  // Subtract with optional borrow and derive every arithmetic flag.
  always_comb begin
    cin  = cmp.withCarry & cmp.oldFlags[FLG_C];
    diff = cmp.opA - cmp.opB - {7'h00, cin};
    cmp.newFlags = cmp.oldFlags;
    cmp.newFlags[FLG_C] = (~cmp.opA[7] & cmp.opB[7]) | (cmp.opB[7] & diff[7]) | (diff[7] & ~cmp.opA[7]);
    cmp.newFlags[FLG_H] = (~cmp.opA[3] & cmp.opB[3]) | (cmp.opB[3] & diff[3]) | (diff[3] & ~cmp.opA[3]);
    cmp.newFlags[FLG_V] = (cmp.opA[7] & ~cmp.opB[7] & ~diff[7]) | (~cmp.opA[7] & cmp.opB[7] & diff[7]);
    cmp.newFlags[FLG_N] = diff[7];
    cmp.newFlags[FLG_S] = diff[7] ^ cmp.newFlags[FLG_V];
    // With carry the zero flag can only stay set, so chained compares work.
    cmp.newFlags[FLG_Z] = (diff == 8'h00) & (~cmp.withCarry | cmp.oldFlags[FLG_Z]);
  end
endmodule // bcs_cmp_flags

// file: bcs_unit.sv
// Purpose: Executes control-flow, compare and copy instructions of the core.
// Assumes: Operand values, pointer and stack top are presented with opValid.
// Notes:   A request is taken on an edge where ce is high and busy is low.
// Functional notes
// - Pointer call pushes return, loads pointer into low PC, clears page bits.
// - Extended pointer call takes page bits from the call page register, three cycles.
// - Compare-skip skips next instruction when both registers equal, no flag change.
// - Register bit zero skip tests selected bit, skips when zero, one to three cycles.
// - Register bit one skip skips next instruction when selected bit is one.
// - I/O bit zero skip skips when the I/O bit is zero, two to four cycles.
// - I/O bit one skip skips when the I/O bit is one, two to four cycles.
// - Status bit one branch adds offset plus one when chosen flag is one.
// - Status bit zero branch adds offset plus one when chosen flag is zero.
// - Carry branches: clear and unsigned ge on carry zero, set and lower on one.
// - Signed ge branch taken when negative xor overflow is zero.
// - Signed less-than branch taken when negative xor overflow is one.
// - Half-carry branches test the half-carry flag for set or clear.
// - User bit branches test the transfer flag for set or clear.
// - Overflow branches test the overflow flag for set or clear.
// - Interrupt branches test the global interrupt enable flag.
`timescale 1ns/100ps
module bcs_unit (
  // Clock, reset and enable.
  input  wire logic                      clk,
  input  wire logic                      rstn,
  input  wire logic                      ce,
  // Instruction request.
  input  wire logic                      opValid,
  input  wire bcs_pkg::bcs_op_e          opCode,
  input  wire logic [7:0]                srcA,
  input  wire logic [7:0]                srcB,
  input  wire logic [15:0]               srcPair,
  input  wire logic [7:0]                immK,
  input  wire logic [2:0]                bitIdx,
  input  wire logic [7:0]                ioData,
  input  wire logic [2:0]                statusSel,
  input  wire logic [bcs_pkg::OFF_W-1:0] offset,
  input  wire logic                      nextIsLong,
  // Pointer, page and stack.
  input  wire logic [15:0]               ptrZ,
  input  wire logic [5:0]                callPage,
  input  wire logic [bcs_pkg::PC_W-1:0]  stackTop,
  // Loads from the rest of the core.
  input  wire logic                      pcLoad,
  input  wire logic [bcs_pkg::PC_W-1:0]  pcIn,
  input  wire logic                      flagLoad,
  input  wire logic [7:0]                flagIn,
  // Status.
  output logic                           busy,
  output logic                           done,
  output logic [bcs_pkg::PC_W-1:0]       pc,
  output logic [7:0]                     statusFlags,
  // Stack and register file strobes.
  output logic                           pushReq,
  output logic [bcs_pkg::PC_W-1:0]       pushAddr,
  output logic                           popReq,
  output logic                           wrEn,
  output logic                           wrPairEn,
  output logic [15:0]                    wrData
);
  import bcs_pkg::*;

  typedef struct packed {
    bcs_phase_e       phase;
    logic [CNT_W-1:0] cnt;
    logic [PC_W-1:0]  pc;
    logic [7:0]       status_flags_register;
    logic [PC_W-1:0]  pendPc;
    logic [7:0]       pendSreg;
    logic             busy;
    logic             done;
    logic             push;
    logic [PC_W-1:0]  pushAddr;
    logic             pop;
    logic             wrEn;
    logic             wrPairEn;
    logic [15:0]      wrData;
  } bcs_state_s;

  bcs_state_s st;
  bcs_state_s next_st;

  bcs_cmp_if cmpBus ();

  logic            accept;
  logic [PC_W-1:0] brTarget;

  // Compare flag generator.
  bcs_cmp_flags uCmp (
    .cmp (cmpBus.calc)
  );

  // Compare operands; the immediate form uses the constant in place of Rr.
  assign cmpBus.opA       = srcA;
  assign cmpBus.opB       = (opCode == OP_CMP_IMM) ? immK : srcB;
  assign cmpBus.withCarry = (opCode == OP_CMP_CARRY);
  assign cmpBus.oldFlags  = st.status_flags_register;

  assign accept   = ce & opValid & (st.phase == PH_IDLE);
  assign brTarget = st.pc + {{(PC_W-OFF_W){offset[OFF_W-1]}}, offset} + STEP_NEXT;

  // Decode, sequencing and retirement, all in one next-state process.
  always_comb begin
    logic [CNT_W-1:0] cyc;
    logic [PC_W-1:0]  tgt;
    logic [7:0]       flg;
    logic             take;
    logic             skip;
    logic             isBranch;
    cyc      = CYC_ONE;
    tgt      = st.pc + STEP_NEXT;
    flg      = st.status_flags_register;
    take     = 1'b0;
    skip     = 1'b0;
    isBranch = 1'b0;
    next_st          = st;
    next_st.done     = 1'b0;
    next_st.push     = 1'b0;
    next_st.pop      = 1'b0;
    next_st.wrEn     = 1'b0;
    next_st.wrPairEn = 1'b0;

    // Other instructions of the core may overwrite PC and flags while idle.
    if (st.phase == PH_IDLE) begin
      if (pcLoad) begin
        next_st.pc = pcIn;
      end
      if (flagLoad) begin
        next_st.status_flags_register = flagIn;
      end
    end

    case (opCode)
      OP_PTR_CALL: begin
        tgt = {6'h00, ptrZ};
        cyc = PC_WIDE ? CYC_PTR_CALL_WIDE : CYC_PTR_CALL_NARR;
      end
      OP_EXT_PTR_CALL: begin
        tgt = {callPage, ptrZ};
        cyc = CYC_EXT_CALL;
      end
      OP_SUB_EXIT, OP_IRQ_EXIT: begin
        tgt = stackTop;
        cyc = PC_WIDE ? CYC_RET_WIDE : CYC_RET_NARR;
        if (opCode == OP_IRQ_EXIT) begin
          flg[FLG_I] = 1'b1;
        end
      end
      OP_CMP_SKIP:   skip = (srcA == srcB);
      OP_SKIP_RBIT0: skip = ~srcB[bitIdx];
      OP_SKIP_RBIT1: skip = srcB[bitIdx];
      OP_SKIP_IO0: begin
        skip = ~ioData[bitIdx];
        cyc  = CYC_ONE + CYC_IO_EXTRA;
      end
      OP_SKIP_IO1: begin
        skip = ioData[bitIdx];
        cyc  = CYC_ONE + CYC_IO_EXTRA;
      end
      OP_CMP_REGS, OP_CMP_CARRY, OP_CMP_IMM: flg = cmpBus.newFlags;
      OP_COPY, OP_COPY_PAIR: ;
      default: isBranch = 1'b1;
    endcase

    // Branch condition per flag and polarity.
    case (opCode)
      OP_BR_SBIT1:  take = st.status_flags_register[statusSel];
      OP_BR_SBIT0:  take = ~st.status_flags_register[statusSel];
      OP_BR_ZERO1:  take = st.status_flags_register[FLG_Z];
      OP_BR_ZERO0:  take = ~st.status_flags_register[FLG_Z];
      OP_BR_NEG:    take = st.status_flags_register[FLG_N];
      OP_BR_NONNEG: take = ~st.status_flags_register[FLG_N];
      OP_BR_CARRY1, OP_BR_ULT: take = st.status_flags_register[FLG_C];
      OP_BR_CARRY0, OP_BR_UGE: take = ~st.status_flags_register[FLG_C];
      OP_BR_SGE:    take = ~(st.status_flags_register[FLG_N] ^ st.status_flags_register[FLG_V]);
      OP_BR_SLT:    take = st.status_flags_register[FLG_N] ^ st.status_flags_register[FLG_V];
      OP_BR_HALF1:  take = st.status_flags_register[FLG_H];
      OP_BR_HALF0:  take = ~st.status_flags_register[FLG_H];
      OP_BR_USER1:  take = st.status_flags_register[FLG_T];
      OP_BR_USER0:  take = ~st.status_flags_register[FLG_T];
      OP_BR_OVF1:   take = st.status_flags_register[FLG_V];
      OP_BR_OVF0:   take = ~st.status_flags_register[FLG_V];
      OP_BR_IRQ1:   take = st.status_flags_register[FLG_I];
      OP_BR_IRQ0:   take = ~st.status_flags_register[FLG_I];
      default:      take = 1'b0;
    endcase

    // A taken branch costs one extra cycle and jumps by offset plus one.
    if (isBranch && take) begin
      tgt = brTarget;
      cyc = cyc + CYC_ONE;
    end

    // A skip steps past a one- or two-word instruction, one cycle per word.
    if (skip) begin
      tgt = st.pc + (nextIsLong ? STEP_SKIP_TWO : STEP_SKIP_ONE);
      cyc = cyc + (nextIsLong ? CYC_TAKEN : CYC_ONE);
    end

    case (st.phase)
      PH_IDLE: begin
        if (accept) begin
          next_st.pendPc   = tgt;
          next_st.pendSreg = flg;
          // Calls push the address of the following word before jumping.
          if (opCode == OP_PTR_CALL || opCode == OP_EXT_PTR_CALL) begin
            next_st.push     = 1'b1;
            next_st.pushAddr = st.pc + STEP_NEXT;
          end
          if (opCode == OP_SUB_EXIT || opCode == OP_IRQ_EXIT) begin
            next_st.pop = 1'b1;
          end
          // Copies write back at once; the destination index lives outside.
          if (opCode == OP_COPY) begin
            next_st.wrEn   = 1'b1;
            next_st.wrData = {8'h00, srcB};
          end
          if (opCode == OP_COPY_PAIR) begin
            next_st.wrPairEn = 1'b1;
            next_st.wrData   = srcPair;
          end
          if (cyc == CYC_ONE) begin
            next_st.pc   = tgt;
            next_st.status_flags_register = flg;
            next_st.done = 1'b1;
          end else begin
            next_st.phase = PH_RUN;
            next_st.busy  = 1'b1;
            next_st.cnt   = cyc - CYC_ONE;
          end
        end
      end
      PH_RUN: begin
        if (st.cnt == CYC_ONE) begin
          next_st.pc    = st.pendPc;
          next_st.status_flags_register  = st.pendSreg;
          next_st.done  = 1'b1;
          next_st.busy  = 1'b0;
          next_st.phase = PH_IDLE;
        end else begin
          next_st.cnt = st.cnt - CYC_ONE;
        end
      end
      default: next_st.phase = PH_IDLE;
    endcase
  end

  // State register; ce low freezes everything.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st          <= '0;
      st.phase    <= PH_IDLE;
      st.pc       <= PC_RST;
      st.status_flags_register     <= STATUS_FLAGS_REGISTER_RST;
      st.pendSreg <= STATUS_FLAGS_REGISTER_RST;
    end else if (ce) begin
      st <= next_st;
    end
  end

  // Outputs come straight from the state register.
  assign busy        = st.busy;
  assign done        = st.done;
  assign pc          = st.pc;
  assign statusFlags = st.status_flags_register;
  assign pushReq     = st.push;
  assign pushAddr    = st.pushAddr;
  assign popReq      = st.pop;
  assign wrEn        = st.wrEn;
  assign wrPairEn    = st.wrPairEn;
  assign wrData      = st.wrData;

  // Checks, valid while ce stays high.
  sequence s_take(bcs_op_e o);
    accept && opCode == o;
  endsequence

  // A taken branch stays busy for one cycle, then retires with busy low.
  sequence s_branch_retire;
    busy ##1 (done && !busy);
  endsequence

  a_ptr_call_jump: assert property (@(posedge clk) disable iff (!rstn || !ce)
    s_take(OP_PTR_CALL) |=> pushReq ##2 done && pc == {6'h00, $past(ptrZ, 3)})
    else $error("Pointer call target or timing wrong.");
  a_ext_call_jump: assert property (@(posedge clk) disable iff (!rstn || !ce)
    s_take(OP_EXT_PTR_CALL) |-> ##3 done && pc == {$past(callPage, 3), $past(ptrZ, 3)})
    else $error("Extended call target or timing wrong.");
  a_cmp_skip_equal: assert property (@(posedge clk) disable iff (!rstn || !ce)
    s_take(OP_CMP_SKIP) ##0 (srcA == srcB && !nextIsLong) |-> ##2 done && pc == $past(pc, 2) + STEP_SKIP_ONE)
    else $error("Compare skip did not skip one word.");
  a_rbit_zero_skip: assert property (@(posedge clk) disable iff (!rstn || !ce)
    s_take(OP_SKIP_RBIT0) ##0 (!srcB[bitIdx] && nextIsLong) |=> !done [*2] ##1 done)
    else $error("Register bit skip over long word took wrong time.");
  a_rbit_one_stay: assert property (@(posedge clk) disable iff (!rstn || !ce)
    s_take(OP_SKIP_RBIT1) ##0 !srcB[bitIdx] |=> done && pc == $past(pc) + STEP_NEXT && $stable(statusFlags))
    else $error("Register bit skip misfired.");
  a_io_zero_skip: assert property (@(posedge clk) disable iff (!rstn || !ce)
    s_take(OP_SKIP_IO0) ##0 (!ioData[bitIdx] && !nextIsLong) |-> ##3 done && pc == $past(pc, 3) + STEP_SKIP_ONE)
    else $error("I/O bit zero skip wrong.");
  a_io_one_stay: assert property (@(posedge clk) disable iff (!rstn || !ce)
    s_take(OP_SKIP_IO1) ##0 !ioData[bitIdx] |=> busy [*1] ##1 done && pc == $past(pc, 2) + STEP_NEXT)
    else $error("I/O bit one skip wrong.");
  a_status_branch: assert property (@(posedge clk) disable iff (!rstn || !ce)
    s_take(OP_BR_SBIT1) ##0 statusFlags[statusSel] |-> ##2 done
      && pc == $past(pc, 2) + {{(PC_W-OFF_W){$past(offset[OFF_W-1], 2)}}, $past(offset, 2)} + STEP_NEXT)
    else $error("Status branch target wrong.");
  a_sbit_zero_fall: assert property (@(posedge clk) disable iff (!rstn || !ce)
    s_take(OP_BR_SBIT0) ##0 statusFlags[statusSel] |=> done && pc == $past(pc) + STEP_NEXT)
    else $error("Status bit zero branch taken wrongly.");
  a_unsigned_ge_take: assert property (@(posedge clk) disable iff (!rstn || !ce)
    s_take(OP_BR_UGE) ##0 !statusFlags[FLG_C] |=> s_branch_retire)
    else $error("Unsigned branch not taken on clear carry.");
  a_signed_ge_fall: assert property (@(posedge clk) disable iff (!rstn || !ce)
    s_take(OP_BR_SGE) ##0 (statusFlags[FLG_N] ^ statusFlags[FLG_V]) |=> done && pc == $past(pc) + STEP_NEXT)
    else $error("Signed branch taken wrongly.");
  a_signed_lt_take: assert property (@(posedge clk) disable iff (!rstn || !ce)
    s_take(OP_BR_SLT) ##0 (statusFlags[FLG_N] ^ statusFlags[FLG_V]) |=> s_branch_retire)
    else $error("Signed less-than branch not taken.");
  a_half_clear_take: assert property (@(posedge clk) disable iff (!rstn || !ce)
    s_take(OP_BR_HALF0) ##0 !statusFlags[FLG_H] |=> s_branch_retire)
    else $error("Half-carry clear branch not taken.");
  a_user_set_take: assert property (@(posedge clk) disable iff (!rstn || !ce)
    s_take(OP_BR_USER1) ##0 statusFlags[FLG_T] |=> s_branch_retire)
    else $error("User bit branch not taken.");
  a_ovf_clear_fall: assert property (@(posedge clk) disable iff (!rstn || !ce)
    s_take(OP_BR_OVF0) ##0 statusFlags[FLG_V] |=> done && $stable(statusFlags))
    else $error("Overflow clear branch taken wrongly.");
  a_irq_on_take: assert property (@(posedge clk) disable iff (!rstn || !ce)
    s_take(OP_BR_IRQ1) ##0 statusFlags[FLG_I] |=> s_branch_retire)
    else $error("Interrupt enabled branch not taken.");
  a_zero_set_take: assert property (@(posedge clk) disable iff (!rstn || !ce)
    s_take(OP_BR_ZERO1) ##0 statusFlags[FLG_Z] |-> ##2 done
      && pc == $past(pc, 2) + {{(PC_W-OFF_W){$past(offset[OFF_W-1], 2)}}, $past(offset, 2)} + STEP_NEXT)
    else $error("Zero branch target wrong.");
  a_compare_only: assert property (@(posedge clk) disable iff (!rstn || !ce)
    s_take(OP_CMP_REGS) |=> done && !wrEn && !wrPairEn && statusFlags == $past(cmpBus.newFlags))
    else $error("Compare wrote a register or wrong flags.");
  a_irq_exit_flag: assert property (@(posedge clk) disable iff (!rstn || !ce)
    s_take(OP_IRQ_EXIT) |=> popReq ##4 done && statusFlags[FLG_I] && pc == $past(stackTop, 5))
    else $error("Interrupt exit wrong.");
  a_pair_copy: assert property (@(posedge clk) disable iff (!rstn || !ce)
    s_take(OP_COPY_PAIR) |=> wrPairEn && done && wrData == $past(srcPair) && $stable(statusFlags))
    else $error("Pair copy wrong.");
endmodule // bcs_unit

// file: tb_branch_call_skip_unit.sv
// Purpose: Self-checking bench for the branch, call and skip unit.
// Assumes: One request in flight at a time, ce high except in the refusal check.
// Notes:   The driver queues each expected result and a monitor compares it on done.
`timescale 1ns/100ps
module tb_branch_call_skip_unit;
  import bcs_pkg::*;

  typedef struct {
    logic [PC_W-1:0] pc;
    logic [7:0]      fl;
    int              n;
    logic [3:0]      st;
    logic [PC_W-1:0] aux;
    int              tk;
  } bcs_note_s;

  // Design inputs, all valued at time zero.
  logic            clk = 1'b0, rstn = 1'b0, ce = 1'b1, opValid = 1'b0, nextIsLong = 1'b0;
  logic            pcLoad = 1'b0, flagLoad = 1'b0;
  bcs_op_e         opCode = OP_COPY;
  logic [7:0]      srcA = 8'h00, srcB = 8'h00, immK = 8'h00, ioData = 8'h00, flagIn = 8'h00;
  logic [2:0]      bitIdx = 3'h0, statusSel = 3'h0;
  logic [OFF_W-1:0] offset = 7'h00;
  logic [15:0]     srcPair = 16'h0000, ptrZ = 16'h0000;
  logic [5:0]      callPage = 6'h00;
  logic [PC_W-1:0] stackTop = 22'h000000, pcIn = 22'h000000;
  // Design outputs.
  logic            busy, done, pushReq, popReq, wrEn, wrPairEn;
  logic [PC_W-1:0] pc, pushAddr;
  logic [7:0]      statusFlags;
  logic [15:0]     wrData;
  // Bench state.
  logic [PC_W-1:0] mpc = 22'h000000;
  logic [7:0]      mfl = 8'h00;
  logic [3:0]      acc = 4'h0;
  int              cyc = 0, mismatches = 0, n_checks = 0, seed = 32'hc048, nb = 0;
  bcs_note_s       q[$];
  bcs_note_s       mnt;

  bcs_unit uut (.clk(clk), .rstn(rstn), .ce(ce), .opValid(opValid), .opCode(opCode), .srcA(srcA),
    .srcB(srcB), .srcPair(srcPair), .immK(immK), .bitIdx(bitIdx), .ioData(ioData), .statusSel(statusSel),
    .offset(offset), .nextIsLong(nextIsLong), .ptrZ(ptrZ), .callPage(callPage), .stackTop(stackTop),
    .pcLoad(pcLoad), .pcIn(pcIn), .flagLoad(flagLoad), .flagIn(flagIn), .busy(busy), .done(done), .pc(pc),
    .statusFlags(statusFlags), .pushReq(pushReq), .pushAddr(pushAddr), .popReq(popReq), .wrEn(wrEn),
    .wrPairEn(wrPairEn), .wrData(wrData));

  // Clock at 40 MHz and a free cycle count for latency checks.
  always #12.5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  // Prints the counts and the verdict, then stops.
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Single comparison point for every check.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Flags of the subtract-and-discard compare, kept T and I untouched.
  function automatic logic [7:0] cmpf(input logic [7:0] a, input logic [7:0] b, input logic wc,
                                      input logic [7:0] f);
    logic [7:0] r;
    logic       c, h, v, z;
    r = a - b - {7'h00, wc & f[FLG_C]};
    c = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
    h = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
    v = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
    z = (r == 8'h00) & (f[FLG_Z] | ~wc);
    return {f[7:6], h, r[7] ^ v, v, r[7], z, c};
  endfunction

  // Branch condition for every status branch form.
  function automatic logic taken(input bcs_op_e op, input logic [7:0] f, input logic [2:0] s);
    case (op)
      OP_BR_SBIT1:                return f[s];
      OP_BR_SBIT0:                return ~f[s];
      OP_BR_ZERO1:                return f[FLG_Z];
      OP_BR_ZERO0:                return ~f[FLG_Z];
      OP_BR_CARRY1, OP_BR_ULT:    return f[FLG_C];
      OP_BR_CARRY0, OP_BR_UGE:    return ~f[FLG_C];
      OP_BR_NEG:                  return f[FLG_N];
      OP_BR_NONNEG:               return ~f[FLG_N];
      OP_BR_SGE:                  return ~(f[FLG_N] ^ f[FLG_V]);
      OP_BR_SLT:                  return f[FLG_N] ^ f[FLG_V];
      OP_BR_HALF1:                return f[FLG_H];
      OP_BR_HALF0:                return ~f[FLG_H];
      OP_BR_USER1:                return f[FLG_T];
      OP_BR_USER0:                return ~f[FLG_T];
      OP_BR_OVF1:                 return f[FLG_V];
      OP_BR_OVF0:                 return ~f[FLG_V];
      OP_BR_IRQ1:                 return f[FLG_I];
      default:                    return ~f[FLG_I];
    endcase
  endfunction

  // Loads program counter and flags while idle.
  task automatic load(input logic [PC_W-1:0] p, input logic [7:0] f);
    pcLoad   <= 1'b1;
    flagLoad <= 1'b1;
    pcIn     <= p;
    flagIn   <= f;
    @(posedge clk);
    pcLoad   <= 1'b0;
    flagLoad <= 1'b0;
    mpc = p;
    mfl = f;
  endtask

  // Presents one request, queues its expected result and waits for done.
  task automatic issue(input bcs_op_e op, input logic [PC_W-1:0] epc, input logic [7:0] efl, input int n,
                       input logic [3:0] st, input logic [PC_W-1:0] aux);
    int k;
    opValid <= 1'b1;
    opCode  <= op;
    @(posedge clk);
    q.push_back('{epc, efl, n, st, aux, cyc});
    opValid <= 1'b0;
    mpc = epc;
    mfl = efl;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (done !== 1'b1 && k < 20);
    if (done !== 1'b1) begin
      mismatches++;
      complete_run();
    end
  endtask

  // Monitor: strobes seen since the last done are gathered, then the oldest note is compared.
  always @(posedge clk) begin
    if (rstn) begin
      acc = acc | {pushReq, popReq, wrEn, wrPairEn};
      if (busy === 1'b1) nb++;
      if (done === 1'b1) begin
        if (q.size() == 0) begin
          check(32'h1, 32'h0);
        end else begin
          mnt = q.pop_front();
          check(pc, mnt.pc);
          check(statusFlags, mnt.fl);
          check(cyc - mnt.tk, mnt.n);
          check(acc, mnt.st);
          check(nb, mnt.n - 1);
          if (mnt.st[3]) check(pushAddr, mnt.aux);
          if (mnt.st[1] | mnt.st[0]) check(wrData, mnt.aux);
        end
        acc = 4'h0;
        nb  = 0;
      end
    end
  end

  // Hang guard.
  initial begin
    repeat (100000) @(posedge clk);
    mismatches++;
    complete_run();
  end

  // Main sequence.
  initial begin
    bcs_op_e    ops;
    bcs_op_e    skl[5];
    logic [7:0] fl, a, b;
    logic [2:0] sel;
    logic [6:0] off;
    logic       sk;
    logic [15:0] pr;
    skl = '{OP_CMP_SKIP, OP_SKIP_RBIT0, OP_SKIP_RBIT1, OP_SKIP_IO0, OP_SKIP_IO1};
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    check(pc, 32'h0);
    check(statusFlags, 32'h0);
    load(22'h000100, 8'h00);
    // A request while ce is low must be ignored.
    ce      <= 1'b0;
    opValid <= 1'b1;
    opCode  <= OP_COPY;
    repeat (3) @(posedge clk);
    opValid <= 1'b0;
    ce      <= 1'b1;
    @(posedge clk);
    check(pc, mpc);
    // Every branch form, offset extremes first, flags flipped on odd passes, N alone for the signed ge and lt forms.
    for (int i = OP_BR_SBIT1; i <= OP_BR_IRQ0; i++) begin
      ops = bcs_op_e'(i);
      fl  = 8'($random(seed));
      for (int j = 0; j < 4; j++) begin
        if (j[0]) fl = fl ^ ((ops == OP_BR_SGE || ops == OP_BR_SLT) ? 8'h04 : 8'hff);
        load(22'($random(seed)), fl);
        sel = 3'($random(seed));
        off = (j == 0) ? 7'h40 : ((j == 1) ? 7'h3f : 7'($random(seed)));
        statusSel <= sel;
        offset    <= off;
        sk = taken(ops, fl, sel);
        issue(ops, sk ? mpc + {{15{off[6]}}, off} + STEP_NEXT : mpc + STEP_NEXT, fl, sk ? 2 : 1, 4'h0, 22'h0);
      end
    end
    // Compare-skip and bit skips, short and long followers.
    for (int j = 0; j < 40; j++) begin
      ops = skl[j % 5];
      a   = 8'($random(seed));
      b   = j[0] ? a : 8'($random(seed));
      fl  = 8'($random(seed));
      sel = 3'($random(seed));
      srcA       <= a;
      srcB       <= b;
      ioData     <= fl;
      bitIdx     <= sel;
      nextIsLong <= j[1];
      case (ops)
        OP_CMP_SKIP:   sk = (a == b);
        OP_SKIP_RBIT0: sk = ~b[sel];
        OP_SKIP_RBIT1: sk = b[sel];
        OP_SKIP_IO0:   sk = ~fl[sel];
        default:       sk = fl[sel];
      endcase
      issue(ops, mpc + (sk ? 22'd2 + 22'(j[1]) : 22'd1), mfl,
            (sk ? 2 + int'(j[1]) : 1) + ((ops == OP_SKIP_IO0 || ops == OP_SKIP_IO1) ? 1 : 0), 4'h0, 22'h0);
    end
    // Compares with random flags, then copies.
    for (int j = 0; j < 24; j++) begin
      ops = (j % 3 == 0) ? OP_CMP_REGS : ((j % 3 == 1) ? OP_CMP_CARRY : OP_CMP_IMM);
      load(mpc, 8'($random(seed)));
      a = 8'($random(seed));
      b = 8'($random(seed));
      srcA <= a;
      srcB <= b;
      immK <= b;
      issue(ops, mpc + STEP_NEXT, cmpf(a, b, ops == OP_CMP_CARRY, mfl), 1, 4'h0, 22'h0);
      pr = 16'($random(seed));
      srcPair <= pr;
      issue(j[0] ? OP_COPY_PAIR : OP_COPY, mpc + STEP_NEXT, mfl, 1, j[0] ? 4'b0001 : 4'b0010,
            j[0] ? {6'h00, pr} : {14'h0000, b});
    end
    // Calls and returns from pages above zero.
    for (int j = 0; j < 8; j++) begin
      load(22'($random(seed)) | 22'h010000, 8'($random(seed)) & 8'h7f);
      a = 8'($random(seed));
      ptrZ     <= 16'($random(seed));
      callPage <= 6'(a);
      stackTop <= 22'($random(seed));
      @(posedge clk);
      case (j % 4)
        0: issue(OP_PTR_CALL, {6'h00, ptrZ}, mfl, 3, 4'b1000, mpc + STEP_NEXT);
        1: issue(OP_EXT_PTR_CALL, {6'(a), ptrZ}, mfl, 3, 4'b1000, mpc + STEP_NEXT);
        2: issue(OP_SUB_EXIT, stackTop, mfl, 5, 4'b0100, 22'h0);
        default: issue(OP_IRQ_EXIT, stackTop, mfl | 8'h80, 5, 4'b0100, 22'h0);
      endcase
    end
    repeat (3) @(posedge clk);
    check(q.size(), 32'h0);
    complete_run();
  end
endmodule // tb_branch_call_skip_unit
